/* hw/ddrio_phase_ref.sv */
`timescale 1ns/1ps
module ddrio_phase_ref (
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rstn,
    input  wire logic                         ce,
    // reference sources
    input  wire logic                         ref_pin,
    input  wire logic                         ref_pll,
    input  wire ddrio_pkg::ddrio_ref_e        ref_sel,
    input  wire logic                         inv,
    // result
    output logic [ddrio_pkg::DLY_W-1:0]       delay_q,
    output logic                              locked_q
);
    import ddrio_pkg::*;

    logic                s1_q, s2_q, s3_q, lvl_q;
    logic [PERIOD_W-1:0] cnt_q, per_q;
    // ------------------------------------------------------------
    // source select and synchroniser
    // ------------------------------------------------------------
    wire logic raw    = ((ref_sel == DDRIO_REF_PLL) ? ref_pll : ref_pin) ^ inv;
    wire logic lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
    wire logic rise   = lvl_d & ~lvl_q;
    // ------------------------------------------------------------
    // delay = quarter of the measured period, clamped to the line
    // ------------------------------------------------------------
    wire logic [PERIOD_W-1:0] per_now = cnt_q + PERIOD_W'(1);
    wire logic [PERIOD_W-1:0] quarter = per_now >> 2;
    wire logic [DLY_W-1:0]    dly_new =
        (quarter < PERIOD_W'(DLY_MIN))   ? DLY_W'(DLY_MIN) :
        (quarter > PERIOD_W'(DLY_DEPTH - 1)) ? DLY_W'(DLY_DEPTH - 1) : quarter[DLY_W-1:0];

    // three-stage sampler, second and third must agree
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end else if (ce) begin
            s1_q  <= raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    // period counter; lock once two periods agree
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q    <= '0;
            per_q    <= '0;
            delay_q  <= DLY_W'(DLY_MIN);
            locked_q <= 1'b0;
        end else if (ce) begin
            cnt_q    <= rise ? '0 : ((&cnt_q) ? cnt_q : cnt_q + PERIOD_W'(1));
            if (rise) begin
                per_q    <= per_now;
                delay_q  <= dly_new;
                locked_q <= (per_now == per_q) && !(&cnt_q);
            end
        end
    end

endmodule

/* hw/ddrio_pin_group.sv */
`timescale 1ns/1ps
// Operation
// [R1] modes: input only, output only, bidirectional, one-hot selected.
// [R2] two capture registers, one per link clock edge.
// [R3] latch holds the high-phase bit so both bits leave on one edge.
// [R4] two launch registers load the array's two paths on rising edges.
// [R5] link clock level selects which launch register drives the pin.
// [R6] first bit on the pin while clock high, second while low.
// [R7] driver enable register holds active-low; array enable inverted first.
// [R8] bidirectional mode uses capture and launch paths on the same pins.
// [R9] falling-edge enable register keeps driver off until the falling edge.
// [R10] strobe group widths 4, 8, 9, 16, 18, 32 or 36 only.
// [R11] strobe capture only in the two top and two bottom banks.
// [R12] strobe passes a compensated delay centring it in the data window.
// [R13] delayed strobe clocks this group's capture registers, not the link clock.
// [R14] top reference sets top strobe delays, bottom reference bottom ones.
// [R15] reference clock runs at strobe frequency; supplied by the far side.
// [R16] only the top plug takes PLL 5, only the bottom plug PLL 6.
// [R17] each reference serves up to 18 strobes: 10 right, 8 left.
// [R18] every input of the element can be inverted individually; one inv_data bit covers all data pins, one inv_ref both references.
// [R19] launch and enable registers share ce_out; capture uses ce_in.
// [R20] registers power up high by preset or low by clear, per parameter.
// [R21] a synchronous reset also returns the registers to power-up value.
// [R22] captured pair: rising-edge sample is the first bit.
module ddrio_pin_group #(
    parameter int   GROUP_W     = ddrio_pkg::GROUP_W_DEF,
    parameter int   BANK        = ddrio_pkg::BANK_TOP_A,
    parameter int   STROBE_SLOT = 0,
    parameter logic PWR_UP_HIGH = ddrio_pkg::PWR_UP_HIGH_DEF
) (
    // clock, reset, enables
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    input  wire logic                       sreset,
    input  wire logic                       ce_in,
    input  wire logic                       ce_out,
    // configuration
    input  wire ddrio_pkg::ddrio_ctrl_s     ctrl,
    // link clock, strobe and reference clocks
    input  wire logic                       link_clk,
    input  wire logic                       strobe,
    input  wire logic                       ref_top_pin,
    input  wire logic                       ref_top_pll5,
    input  wire logic                       ref_bot_pin,
    input  wire logic                       ref_bot_pll6,
    // data pins
    input  wire logic [GROUP_W-1:0]         pin_i,
    output logic      [GROUP_W-1:0]         pin_o,
    output logic      [GROUP_W-1:0]         pin_oe,
    // logic array side
    input  wire logic [GROUP_W-1:0]         tx_first,
    input  wire logic [GROUP_W-1:0]         tx_second,
    input  wire logic                       tx_oe,
    output ddrio_pkg::ddrio_pair_s [GROUP_W-1:0] rx_pair,
    output logic                            rx_valid,
    // status
    output logic [ddrio_pkg::DLY_W-1:0]     strobe_tap,
    output logic                            strobe_active,
    output logic                            ref_locked_top,
    output logic                            ref_locked_bot
);
    import ddrio_pkg::*;

    localparam int SW = GROUP_W + 2;
    localparam logic [GROUP_W-1:0] RST_VAL = {GROUP_W{PWR_UP_HIGH}}; // R20

    // ------------------------------------------------------------
    // static placement checks
    // ------------------------------------------------------------
    localparam logic BANK_TOP  = (BANK == BANK_TOP_A) || (BANK == BANK_TOP_B);
    localparam logic BANK_BOT  = (BANK == BANK_BOT_A) || (BANK == BANK_BOT_B);
    localparam logic WIDTH_OK  = ddrio_width_ok(GROUP_W);                  // R10
    localparam logic SLOT_OK   = (STROBE_SLOT >= 0) &&
                                 (STROBE_SLOT < STROBE_RIGHT + STROBE_LEFT); // R17
    localparam logic STROBE_OK = (BANK_TOP || BANK_BOT) && WIDTH_OK && SLOT_OK; // R11

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [SW-1:0]        s1_q, s2_q, s3_q, filt_q;
    logic                 clk_prev_q;
    logic [DLY_DEPTH-1:0] dly_q;
    logic                 stb_tap_q;
    logic [GROUP_W-1:0]   rise_q, fall_q, lat_q;
    logic [GROUP_W-1:0]   out_a_q, out_b_q, pin_o_q, pin_oe_q;
    logic                 oe_n_q, oe_neg_n_q;
    ddrio_pair_s [GROUP_W-1:0] rx_pair_q;
    logic                 rx_valid_q;
    logic [DLY_W-1:0]     tap_q;
    logic                 stb_act_q;
    logic [DLY_W-1:0]     top_dly, bot_dly;

    // ------------------------------------------------------------
    // input inversion and sampling
    // ------------------------------------------------------------
    // each pin input may be inverted before it is sampled
    wire logic [SW-1:0] raw_in = {link_clk ^ ctrl.inv_clk,
                                  strobe ^ ctrl.inv_strobe,
                                  pin_i ^ {GROUP_W{ctrl.inv_data}}}; // R18
    // a bit moves only once stages two and three agree
    wire logic [SW-1:0] filt_d = (s2_q ~^ s3_q) & s3_q | (s2_q ^ s3_q) & filt_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            filt_q <= '0;
        end else if (ce) begin
            s1_q   <= raw_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    wire logic [GROUP_W-1:0] din = filt_q[GROUP_W-1:0];
    wire logic clk_lvl = filt_q[SW-1];
    wire logic stb_lvl = filt_q[SW-2];

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire logic mode_in  = (ctrl.mode == DDRIO_MODE_IN);    // R1
    wire logic mode_out = (ctrl.mode == DDRIO_MODE_OUT);
    wire logic mode_bi  = (ctrl.mode == DDRIO_MODE_BIDIR);
    wire logic cap_on   = (mode_in || mode_bi) && ce_in;   // R8 R19
    wire logic lau_on   = (mode_out || mode_bi) && ce_out; // R8 R19
    wire logic use_stb  = ctrl.strobe_en && STROBE_OK;     // R11

    // ------------------------------------------------------------
    // phase-shift references, one per side
    // ------------------------------------------------------------
    // top plug only reaches PLL 5, bottom plug only PLL 6
    ddrio_phase_ref u_ref_top (                             // R14 R16
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .ref_pin (ref_top_pin),
        .ref_pll (ref_top_pll5),
        .ref_sel (ctrl.ref_top),
        .inv     (ctrl.inv_ref),
        .delay_q (top_dly),
        .locked_q(ref_locked_top)
    );

    ddrio_phase_ref u_ref_bot (                             // R14 R16
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .ref_pin (ref_bot_pin),
        .ref_pll (ref_bot_pll6),
        .ref_sel (ctrl.ref_bot),
        .inv     (ctrl.inv_ref),
        .delay_q (bot_dly),
        .locked_q(ref_locked_bot)
    );

    // ------------------------------------------------------------
    // compensated strobe delay
    // ------------------------------------------------------------
    // a quarter period of the reference lands the strobe mid-window;
    // this assumes the reference really runs at strobe rate
    wire logic [DLY_W-1:0] side_dly = BANK_TOP ? top_dly : bot_dly; // R14 R15
    // stage 0 already lags one cycle, so the edge lands exactly tap cycles late
    wire logic             stb_tap_d = dly_q[tap_q - DLY_W'(1)];    // R12

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dly_q      <= '0;
            stb_tap_q  <= 1'b0;
            tap_q      <= '0;
            stb_act_q  <= 1'b0;
        end else if (ce) begin
            dly_q      <= {dly_q[DLY_DEPTH-2:0], stb_lvl};
            stb_tap_q  <= stb_tap_d;                                 // R12
            tap_q      <= STROBE_OK ? side_dly : '0;                 // R14
            stb_act_q  <= use_stb;
        end
    end

    // ------------------------------------------------------------
    // edge events
    // ------------------------------------------------------------
    wire logic clk_rise = clk_lvl & ~clk_prev_q;
    wire logic clk_fall = ~clk_lvl & clk_prev_q;
    wire logic stb_rise = stb_tap_d & ~stb_tap_q;
    wire logic stb_fall = ~stb_tap_d & stb_tap_q;
    // capture follows the delayed strobe bus when strobe mode is live
    wire logic cap_rise = use_stb ? stb_rise : clk_rise;            // R13
    wire logic cap_fall = use_stb ? stb_fall : clk_fall;            // R13

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clk_prev_q <= 1'b0;
        end else if (ce) begin
            clk_prev_q <= clk_lvl;
        end
    end

    // ------------------------------------------------------------
    // capture path
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rise_q <= RST_VAL;
            fall_q <= RST_VAL;
            lat_q  <= RST_VAL;
        end else if (ce) begin
            if (sreset) begin                                        // R21
                rise_q <= RST_VAL;
                fall_q <= RST_VAL;
                lat_q  <= RST_VAL;
            end else if (cap_on) begin
                if (cap_rise) rise_q <= din;                         // R2
                if (cap_fall) fall_q <= din;                         // R2
                if (cap_fall) lat_q  <= rise_q;                      // R3
            end
        end
    end

    // pair leaves on the rising edge, rising sample first
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_pair_q  <= '0;
            rx_valid_q <= 1'b0;
        end else if (ce) begin
            rx_valid_q <= cap_on && cap_rise && !sreset;
            if (cap_on && cap_rise && !sreset) begin
                for (int i = 0; i < GROUP_W; i++) begin
                    rx_pair_q[i].first  <= lat_q[i];                 // R22 R3
                    rx_pair_q[i].second <= fall_q[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // launch path
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            out_a_q <= RST_VAL;
            out_b_q <= RST_VAL;
            oe_n_q  <= OE_N_RST;
        end else if (ce) begin
            if (sreset) begin                                        // R21
                out_a_q <= RST_VAL;
                out_b_q <= RST_VAL;
                oe_n_q  <= OE_N_RST;
            end else if (lau_on && clk_rise) begin
                out_a_q <= tx_first;                                 // R4
                out_b_q <= tx_second;                                // R4
                oe_n_q  <= ~tx_oe;                                   // R7
            end
        end
    end

    // falling-edge copy of the enable holds the driver off a half cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            oe_neg_n_q <= OE_N_RST;
        end else if (ce) begin
            if (sreset) oe_neg_n_q <= OE_N_RST;
            else if (clk_fall && ce_out) oe_neg_n_q <= oe_n_q;       // R9
        end
    end

    // clock level picks the register; active-low enable turned for the port
    wire logic [GROUP_W-1:0] pin_sel = clk_lvl ? out_a_q : out_b_q; // R5 R6
    wire logic               drv_n   = mode_bi ? oe_neg_n_q :
                                       (mode_out ? oe_n_q : 1'b1);  // R7 R9

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_o_q  <= RST_VAL;
            pin_oe_q <= '0;
        end else if (ce) begin
            pin_o_q  <= pin_sel;                                     // R6
            pin_oe_q <= {GROUP_W{~drv_n}};                           // R7
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pin_o         = pin_o_q;
    assign pin_oe        = pin_oe_q;
    assign rx_pair       = rx_pair_q;
    assign rx_valid      = rx_valid_q;
    assign strobe_tap    = tap_q;
    assign strobe_active = stb_act_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_input_mode_only: assert property (ce && !(mode_in || mode_bi) |=> !rx_valid_q) // R1
        else $error("pair delivered outside input modes");
    a_rise_capture: assert property (ce && cap_on && cap_rise && !sreset |=> rise_q == $past(din)) // R2
        else $error("rising sample not captured");
    a_pair_order: assert property (ce && cap_on && cap_rise && !sreset |=>
                                   rx_valid_q && rx_pair_q[0].first == $past(lat_q[0]) &&
                                   rx_pair_q[0].second == $past(fall_q[0])) // R22
        else $error("rising sample not first in pair");
    a_launch_load: assert property (ce && lau_on && clk_rise && !sreset |=>
                                    out_a_q == $past(tx_first) && out_b_q == $past(tx_second)) // R4
        else $error("launch registers did not load");
    a_pin_low_phase: assert property (ce && !clk_lvl ##1 ce |-> pin_o_q == $past(out_b_q)) // R6
        else $error("second bit not on pin in low phase");
    a_oe_inverted: assert property (ce && mode_out && $past(ce) && $past(mode_out) |->
                                    pin_oe_q[0] == !$past(oe_n_q)) // R7
        else $error("driver enable polarity wrong");
    a_oe_bidir_wait: assert property (mode_bi && $past(mode_bi) && $past(mode_bi, 2) &&
                                      $rose(pin_oe_q[0]) |-> $past(clk_fall, 2)) // R9
        else $error("bidir driver enabled before falling edge");
    a_strobe_gate: assert property (ce && ctrl.strobe_en && STROBE_OK |=> stb_act_q) // R11
        else $error("strobe mode not taken in legal bank");
    a_tap_side: assert property (ce && STROBE_OK |=> tap_q == $past(side_dly)) // R14
        else $error("strobe tap not from own side reference");
    a_sync_reset: assert property (ce && sreset |=> rise_q == RST_VAL && out_a_q == RST_VAL) // R21
        else $error("synchronous reset did not restore registers");

    c_bidir_pair: cover property (mode_bi && rx_valid_q ##[1:20] $rose(pin_oe_q[0]));
    c_strobe_cap: cover property (stb_act_q && rx_valid_q);
    c_out_toggle: cover property (mode_out && pin_oe_q[0] ##1 pin_o_q[0] != $past(pin_o_q[0]));

endmodule

/* hw/ddrio_pkg.sv */
package ddrio_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int LINK_PERIOD_NS = 400;
    // nominal link period in system clocks, a sizing hint only
    localparam int LINK_CYCLES    = LINK_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // strobe delay line and reference measurement
    // ------------------------------------------------------------
    localparam int DLY_DEPTH      = 16;
    localparam int DLY_W          = 4;
    localparam int PERIOD_W       = 8;
    localparam int DLY_MIN        = 1;

    // ------------------------------------------------------------
    // group geometry
    // ------------------------------------------------------------
    localparam int GROUP_W_DEF    = 8;
    localparam int STROBE_PER_SIDE = 18;
    localparam int STROBE_RIGHT   = 10;
    localparam int STROBE_LEFT    = 8;
    localparam int BANK_TOP_A     = 3;
    localparam int BANK_TOP_B     = 4;
    localparam int BANK_BOT_A     = 7;
    localparam int BANK_BOT_B     = 8;
    localparam int PLL_TOP_ID     = 5;
    localparam int PLL_BOT_ID     = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic PWR_UP_HIGH_DEF = 1'b0;
    localparam logic OE_N_RST        = 1'b1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DDRIO_MODE_IN    = 3'b001,
        DDRIO_MODE_OUT   = 3'b010,
        DDRIO_MODE_BIDIR = 3'b100
    } ddrio_mode_e;

    typedef enum logic [1:0] {
        DDRIO_REF_PIN = 2'b01,
        DDRIO_REF_PLL = 2'b10
    } ddrio_ref_e;

    typedef struct packed {
        ddrio_mode_e mode;
        logic        strobe_en;
        ddrio_ref_e  ref_top;
        ddrio_ref_e  ref_bot;
        logic        inv_data;
        logic        inv_strobe;
        logic        inv_clk;
        logic        inv_ref;
    } ddrio_ctrl_s;

    typedef struct packed {
        logic first;
        logic second;
    } ddrio_pair_s;

    // legal strobe group widths
    function automatic logic ddrio_width_ok(input int w);
        return (w == 4) || (w == 8) || (w == 9) || (w == 16) ||
               (w == 18) || (w == 32) || (w == 36);
    endfunction

endpackage

/* tb/ddrio_mem_model.sv */
`timescale 1ns/1ps
module ddrio_mem_model (
    // clocks toward the device
    output logic       link_clk,
    output logic       strobe,
    output logic       ref_clk,
    // read data lines
    output logic [7:0] dq
);
    // --------------
    // memory side
    // --------------
    // reference runs free at strobe rate, link clock only in frames
    initial begin
        ref_clk = 1'b0;
        forever #200 ref_clk = ~ref_clk;
    end
    // strobe leaves edge-aligned with the data on reads, link clock centred
    initial begin
        link_clk = 1'b0;
        strobe = 1'b0;
        dq = 8'h00;
    end
    // one period; lines flip once hold is over, never twice in one step
    task automatic send(input logic [7:0] first, input logic [7:0] second);
        dq = first;
        strobe = 1'b1;
        #100 link_clk = 1'b1;
        #100 dq = second;
        strobe = 1'b0;
        #100 link_clk = 1'b0;
        #50 dq = ~second;
        #50;
    endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import ddrio_pkg::*;
    // --------------
    // signals
    // --------------
    logic              clk_sys;
    logic              rstn;
    logic              sreset;
    ddrio_ctrl_s       ctrl;
    logic              link_clk;
    logic              strobe;
    logic              ref_clk;
    logic [7:0]        mem_dq;
    logic [7:0]        tx_first;
    logic [7:0]        tx_second;
    logic              tx_oe;
    logic [7:0]        pin_o;
    logic [7:0]        pin_oe;
    wire  [7:0]        pin_i;
    ddrio_pair_s [7:0] rx_pair;
    logic              rx_valid;
    logic [DLY_W-1:0]  strobe_tap;
    logic              lock_top;
    logic              lock_bot;
    logic              stb_act;
    logic [7:0]        got_f;
    logic [7:0]        got_s;
    logic [15:0]       exp_q[$];
    logic              watch = 1'b1;
    int                num_errors = 0;
    int                checked = 0;
    // the wire follows whichever side has its driver on
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & mem_dq);
    initial begin
        clk_sys = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end
    ddrio_mem_model MEM (.link_clk(link_clk), .strobe(strobe), .ref_clk(ref_clk), .dq(mem_dq));
    ddrio_pin_group DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .sreset(sreset),
        .ce_in(1'b1), .ce_out(1'b1), .ctrl(ctrl), .link_clk(link_clk), .strobe(strobe),
        .ref_top_pin(ref_clk), .ref_top_pll5(1'b0), .ref_bot_pin(1'b0),
        .ref_bot_pll6(ref_clk), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .tx_first(tx_first), .tx_second(tx_second), .tx_oe(tx_oe), .rx_pair(rx_pair),
        .rx_valid(rx_valid), .strobe_tap(strobe_tap), .strobe_active(stb_act),
        .ref_locked_top(lock_top), .ref_locked_bot(lock_bot));
    // --------------
    // tasks
    // --------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // config changes only once the last edge event of the link has drained
    task automatic setup(input ddrio_mode_e m, input logic inv, input logic oe);
        repeat (4) @(posedge clk_sys);
        #2;
        ctrl.mode = m;
        ctrl.inv_data = inv;
        tx_oe = oe;
        tx_first = 8'($urandom);
        tx_second = 8'($urandom);
    endtask
    // model pushes what the memory sends, inverted when asked
    task automatic cap_period();
        logic [7:0] f;
        logic [7:0] s;
        f = 8'($urandom);
        s = 8'($urandom);
        exp_q.push_back(ctrl.inv_data ? ~{f, s} : {f, s});
        MEM.send(f, s);
    endtask
    // probes sit late in each half period: the pin lags about six clocks
    task automatic out_period(input logic [7:0] oe_hi, input logic [7:0] oe_lo);
        fork
            begin
                #475 chk(pin_o, tx_first, "high phase bit");
                chk(pin_oe, oe_hi, "enable high phase");
                #200 chk(pin_o, tx_second, "low phase bit");
                chk(pin_oe, oe_lo, "enable low phase");
            end
        join_none
        MEM.send(8'($urandom), 8'($urandom));
    endtask
    // every captured pair is matched against the model queue while watch is set
    always @(posedge clk_sys) begin
        if (watch && rx_valid === 1'b1) begin
            for (int i = 0; i < 8; i++) begin
                got_f[i] = rx_pair[i].first;
                got_s[i] = rx_pair[i].second;
            end
            if (exp_q.size() == 0) begin
                chk(8'hFF, 8'h00, "pair without data");
            end else begin
                chk(got_f, exp_q[0][15:8], "rising sample");
                chk(got_s, exp_q[0][7:0], "falling sample");
                void'(exp_q.pop_front());
            end
        end
    end
    // --------------
    // sequence
    // --------------
    initial begin
        ctrl = '0;
        ctrl.ref_top = DDRIO_REF_PIN;
        ctrl.ref_bot = DDRIO_REF_PLL;
        {rstn, sreset, tx_first, tx_second, tx_oe} = '0;
        void'($urandom(32'h17B2));
        repeat (3) @(posedge clk_sys);
        #2 rstn = 1'b1;
        repeat (2) @(posedge clk_sys);
        #2 chk(pin_o, 8'h00, "reset data");
        chk(pin_oe, 8'h00, "reset enable");
        // the first pair out carries the power-up content of the capture registers
        exp_q.push_back({16{PWR_UP_HIGH_DEF}});
        for (int m = 0; m < 4; m++) begin
            setup(m[1] ? DDRIO_MODE_BIDIR : DDRIO_MODE_IN, m[0], 1'b0);
            ctrl.strobe_en = m[1] ^ m[0];
            repeat (6) cap_period();
            chk({7'h00, stb_act}, {7'h00, m[1] ^ m[0]}, "strobe mode");
        end
        watch = 1'b0;
        for (int k = 0; k < 2; k++) begin
            setup(DDRIO_MODE_OUT, 1'b0, k[0]);
            repeat (3) out_period({8{k[0]}}, {8{k[0]}});
            #300;
        end
        setup(DDRIO_MODE_BIDIR, 1'b0, 1'b0);
        MEM.send(8'h00, 8'h00);
        setup(DDRIO_MODE_BIDIR, 1'b0, 1'b1);
        out_period(8'h00, 8'hFF);
        #300 sreset = 1'b1;
        repeat (3) @(posedge clk_sys);
        #2 chk(pin_o, 8'h00, "sync reset data");
        chk(pin_oe, 8'h00, "sync reset enable");
        sreset = 1'b0;
        chk({7'h00, lock_top}, 8'h01, "top lock");
        chk({7'h00, lock_bot}, 8'h01, "bottom lock");
        chk({4'h0, strobe_tap}, 8'(LINK_CYCLES / 4), "strobe tap");
        report_and_stop();
    end
    // about forty link periods are planned; allow over twelve times that
    initial begin
        #200000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule
